// ---- hw/css_params.svh ----
// Purpose: Timing and field constants of the charge safety supervisor.
// Assumes: A 250 MHz core clock.
// Notes: Definitions only.
`ifndef CSS_PARAMS_SVH
`define CSS_PARAMS_SVH
`define CSS_CLK_NS 4
// The safety and watchdog timers advance on a 1 ms tick.
`define CSS_TICK_NS 1000000
`define CSS_TICK_CYCLES (`CSS_TICK_NS / `CSS_CLK_NS)
`define CSS_WDOG_S 50
`define CSS_WDOG_TICKS (`CSS_WDOG_S * 1000)
`define CSS_ALERT_US 128
`define CSS_ALERT_CYCLES (`CSS_ALERT_US * 1000 / `CSS_CLK_NS)
// Pre-charge limit is one tenth of the maximum charge time.
`define CSS_PRE_DIV 32'hA
`define CSS_SEL_OFF 2'h0
`define CSS_SEL_T1 2'h1
`define CSS_SEL_T2 2'h2
`define CSS_T1_MS 2700000
`define CSS_T2_MS 10800000
`define CSS_T3_MS 21600000
`endif

// ---- hw/css_pkg.sv ----
// Purpose: Types shared by the charge safety supervisor.
// Assumes: Nothing beyond the constants header.
// Notes: State codes are written out.
package css_pkg;
   typedef enum logic [2:0] {
      CSS_IDLE = 3'h0,
      CSS_CHARGE = 3'h1,
      CSS_SUSPEND = 3'h2,
      CSS_DONE = 3'h3,
      CSS_FAULT = 3'h4,
      CSS_SHUTDOWN = 3'h5
   } css_state_type;
endpackage

// ---- hw/css_supervisor.sv ----
// Purpose: Safety timer, host watchdog, thermistor and die temperature supervision.
// Assumes: All inputs synchronous to clk; analog comparators outside.
// Notes: Safety and watchdog timers run on a 1 ms tick derived from clk; the alert pulse counts clk cycles.
`include "css_params.svh"
`timescale 1ns/1ps
`default_nettype none

module css_supervisor
   import css_pkg::*;
#(
   parameter int TICK_CYCLES = `CSS_TICK_CYCLES,
   parameter int ALERT_CYCLES = `CSS_ALERT_CYCLES,
   parameter int WDOG_TICKS = `CSS_WDOG_TICKS,
   parameter int MAX_T1_TICKS = `CSS_T1_MS,
   parameter int MAX_T2_TICKS = `CSS_T2_MS,
   parameter int MAX_T3_TICKS = `CSS_T3_MS
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Charge control.
   input wire logic input_valid,
   input wire logic chip_disable_pin,
   input wire logic charge_enable_n,
   input wire logic [1:0] safety_time_select,
   input wire logic safety_time_write,
   input wire logic half_rate_timer_enable,
   input wire logic precharge_phase,
   input wire logic other_loop_active,
   input wire logic charge_terminated,
   input wire logic charge_current_set_pin_grounded,
   // Host bus activity.
   input wire logic i2c_transaction,
   // Thermistor zones and die temperature.
   input wire logic ts_cold,
   input wire logic ts_cool,
   input wire logic ts_warm,
   input wire logic ts_hot,
   input wire logic ts_disabled,
   input wire logic die_overtemp,
   input wire logic die_cooled,
   // Charger controls.
   output logic charge_enable,
   output logic half_current,
   output logic vreg_lower,
   output logic use_default_charge_current_set_pin,
   output logic mid_supply_enable,
   output logic system_output_enable,
   output logic aux_output_enable,
   // Status.
   output logic [2:0] charge_status,
   output logic timer_fault,
   output logic thermal_shutdown,
   output logic regs_to_default,
   // Open-drain host alert.
   output logic host_alert_o,
   output logic host_alert_oe
);

   // Maximum time for a select code; zero means the timer is off.
   function automatic logic [31:0] max_time(input logic [1:0] sel);
      logic [31:0] t;
      t = 32'h0;
      if (sel == `CSS_SEL_T1) begin
         t = 32'(MAX_T1_TICKS);
      end else if (sel == `CSS_SEL_T2) begin
         t = 32'(MAX_T2_TICKS);
      end else if (sel != `CSS_SEL_OFF) begin
         t = 32'(MAX_T3_TICKS);
      end
      return t;
   endfunction

   css_state_type state, next_state;
   logic [31:0] pre_cnt, next_pre_cnt;
   logic [31:0] safety_cnt, next_safety_cnt;
   logic half_phase, next_half_phase;
   logic wd_active, next_wd_active;
   logic [31:0] wd_cnt, next_wd_cnt;
   logic [31:0] alert_cnt, next_alert_cnt;
   logic tick, enabled, ts_stop, slow, cnt_go, expired, pre_over, wd_expire;
   logic [31:0] limit, inc_cnt;

   // Millisecond prescaler shared by both timers.
   always_comb begin
      tick = (pre_cnt == 32'(TICK_CYCLES - 1));
      next_pre_cnt = tick ? 32'h0 : pre_cnt + 32'h1;
   end

   // Charge cycle and safety timer.
   always_comb begin
      enabled = input_valid && !chip_disable_pin && !charge_enable_n;
      ts_stop = !ts_disabled && (ts_hot || ts_cold);
      slow = half_rate_timer_enable && other_loop_active;
      cnt_go = tick && (!slow || half_phase);
      limit = max_time(safety_time_select);
      inc_cnt = safety_cnt + 32'h1;
      expired = cnt_go && (limit != 32'h0) && (inc_cnt >= limit);
      pre_over = cnt_go && (limit != 32'h0) && precharge_phase
                 && (inc_cnt >= limit / `CSS_PRE_DIV);
      next_state = state;
      next_safety_cnt = safety_cnt;
      next_half_phase = half_phase;
      unique case (state)
         CSS_IDLE: begin
            if (enabled && !die_overtemp) begin
               next_state = CSS_CHARGE;
               next_safety_cnt = 32'h0;
               next_half_phase = 1'b0;
            end
         end
         CSS_CHARGE, CSS_SUSPEND: begin
            if (!enabled) begin
               next_state = CSS_IDLE;
            end else if (die_overtemp) begin
               next_state = CSS_SHUTDOWN;
               next_safety_cnt = 32'h0;
            end else if (ts_stop) begin
               next_state = CSS_SUSPEND;
            end else if (state == CSS_SUSPEND) begin
               next_state = CSS_CHARGE;
            end else if (safety_time_write) begin
               next_safety_cnt = 32'h0;
            end else if (charge_terminated) begin
               next_state = CSS_DONE;
            end else if (expired || pre_over) begin
               next_state = CSS_FAULT;
            end else if (tick) begin
               next_half_phase = !half_phase;
               if (cnt_go) begin
                  next_safety_cnt = inc_cnt;
               end
            end
         end
         CSS_DONE: begin
            if (!enabled) begin
               next_state = CSS_IDLE;
            end
         end
         CSS_FAULT: begin
            // Only the pin clears the latch; the host enable bit does not.
            if (chip_disable_pin) begin
               next_state = CSS_IDLE;
            end
         end
         CSS_SHUTDOWN: begin
            next_safety_cnt = 32'h0;
            if (!enabled) begin
               next_state = CSS_IDLE;
            end else if (die_cooled) begin
               next_state = CSS_CHARGE;
            end
         end
         default: begin
            next_state = CSS_IDLE;
         end
      endcase
   end

   // Host watchdog; it is untouched by thermal shutdown.
   always_comb begin
      wd_expire = wd_active && tick && !i2c_transaction
                  && (wd_cnt == 32'(WDOG_TICKS - 1));
      next_wd_active = wd_active;
      next_wd_cnt = wd_cnt;
      if (i2c_transaction) begin
         next_wd_active = 1'b1;
         next_wd_cnt = 32'h0;
      end else if (wd_expire) begin
         next_wd_active = 1'b0;
         next_wd_cnt = 32'h0;
      end else if (wd_active && tick) begin
         next_wd_cnt = wd_cnt + 32'h1;
      end
   end

   // Alert pulse timer, armed on entry to the fault state.
   always_comb begin
      next_alert_cnt = alert_cnt;
      if (next_state == CSS_FAULT && state != CSS_FAULT) begin
         next_alert_cnt = 32'(ALERT_CYCLES);
      end else if (alert_cnt != 32'h0) begin
         next_alert_cnt = alert_cnt - 32'h1;
      end
   end

   // Registers; outputs are taken from next values so they track state.
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= CSS_IDLE;
         pre_cnt <= 32'h0;
         safety_cnt <= 32'h0;
         half_phase <= 1'b0;
         wd_active <= 1'b0;
         wd_cnt <= 32'h0;
         alert_cnt <= 32'h0;
         charge_enable <= 1'b0;
         half_current <= 1'b0;
         vreg_lower <= 1'b0;
         use_default_charge_current_set_pin <= 1'b0;
         mid_supply_enable <= 1'b1;
         system_output_enable <= 1'b1;
         aux_output_enable <= 1'b1;
         charge_status <= 3'h0;
         timer_fault <= 1'b0;
         thermal_shutdown <= 1'b0;
         regs_to_default <= 1'b0;
         host_alert_o <= 1'b0;
         host_alert_oe <= 1'b0;
      end else begin
         state <= next_state;
         pre_cnt <= next_pre_cnt;
         safety_cnt <= next_safety_cnt;
         half_phase <= next_half_phase;
         wd_active <= next_wd_active;
         wd_cnt <= next_wd_cnt;
         alert_cnt <= next_alert_cnt;
         charge_enable <= (next_state == CSS_CHARGE);
         half_current <= !ts_disabled && ts_cool;
         vreg_lower <= !ts_disabled && ts_warm;
         use_default_charge_current_set_pin <= charge_current_set_pin_grounded;
         mid_supply_enable <= (next_state != CSS_SHUTDOWN);
         system_output_enable <= (next_state != CSS_SHUTDOWN);
         aux_output_enable <= (next_state != CSS_SHUTDOWN);
         charge_status <= next_state;
         timer_fault <= (next_state == CSS_FAULT);
         thermal_shutdown <= (next_state == CSS_SHUTDOWN);
         regs_to_default <= wd_expire;
         host_alert_o <= 1'b0;
         host_alert_oe <= (next_alert_cnt != 32'h0);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_cycle_starts_timer: assert property (
      state == CSS_IDLE && enabled && !die_overtemp
      |=> state == CSS_CHARGE && safety_cnt == 32'h0 && charge_enable)
      else $error("charge cycle did not start timer");
   a_max_time_fault: assert property (
      state == CSS_CHARGE && enabled && !die_overtemp && !ts_stop
      && !safety_time_write && !charge_terminated && expired
      |=> state == CSS_FAULT && !charge_enable && timer_fault)
      else $error("expired timer did not fault");
   a_precharge_limit: assert property (
      state == CSS_CHARGE && precharge_phase && limit != 32'h0
      && !$changed(safety_time_select) && !$changed(precharge_phase)
      |-> safety_cnt < limit / `CSS_PRE_DIV)
      else $error("pre-charge ran past its limit");
   a_fault_alert_pulse: assert property (
      state != CSS_FAULT ##1 state == CSS_FAULT
      |-> host_alert_oe [*8] ##0 !host_alert_o)
      else $error("no alert pulse on timer fault");
   a_fault_latched: assert property (
      state == CSS_FAULT && !chip_disable_pin |=> state == CSS_FAULT)
      else $error("timer fault cleared without pin");
   a_duration_restart: assert property (
      state == CSS_CHARGE && enabled && !die_overtemp && !ts_stop
      && safety_time_write |=> safety_cnt == 32'h0)
      else $error("duration write did not restart timer");
   a_wdog_idle: assert property (
      !wd_active && !i2c_transaction |=> !wd_active && !regs_to_default)
      else $error("watchdog ran before first transaction");
   a_wdog_restart: assert property (
      i2c_transaction |=> wd_active && wd_cnt == 32'h0 && !regs_to_default)
      else $error("transaction did not restart watchdog");
   a_wdog_expiry: assert property (
      wd_expire |=> regs_to_default && !wd_active ##1 !regs_to_default)
      else $error("watchdog expiry not handled");
   a_ts_hold: assert property (
      state == CSS_SUSPEND ##1 state == CSS_SUSPEND
      |-> $stable(safety_cnt) && !charge_enable)
      else $error("timer moved while suspended");
   a_thermal_off: assert property (
      state == CSS_SHUTDOWN |-> !mid_supply_enable && !charge_enable
      && safety_cnt == 32'h0 && thermal_shutdown)
      else $error("shutdown left outputs or timer running");

   c_timer_fault: cover property (state == CSS_CHARGE ##1 state == CSS_FAULT);
   c_shutdown_resume: cover property (state == CSS_SHUTDOWN ##1 state == CSS_CHARGE);
   c_wdog_expire: cover property (regs_to_default);
   c_ts_suspend: cover property (state == CSS_SUSPEND ##1 state == CSS_CHARGE);

endmodule
`default_nettype wire

// ---- verif/css_host_model.sv ----
// Purpose: Host processor model that writes the charge control fields over the bus.
// Assumes: One bus transaction lasts one clk cycle and starts at a falling edge.
// Notes: Driven only through its task; it never changes a field outside a transaction.
`timescale 1ns/1ps
`default_nettype none
module css_host_model (
   // Clock.
   input wire logic clk,
   // Register bits written by the host.
   output logic i2c_transaction,
   output logic charge_enable_n,
   output logic [1:0] safety_time_select,
   output logic safety_time_write
);
   // The bus idles with charging disabled until the host asks for it.
   initial begin
      i2c_transaction = 1'h0;
      charge_enable_n = 1'h1;
      safety_time_select = 2'h0;
      safety_time_write = 1'h0;
   end
   // Each call is one transaction, which also feeds the watchdog.
   task automatic bus_write(input logic ce_n, input logic [1:0] sel, input logic wr_sel);
      @(negedge clk);
      i2c_transaction <= 1'h1;
      charge_enable_n <= ce_n;
      if (wr_sel) begin
         safety_time_select <= sel;
         safety_time_write <= 1'h1;
      end
      @(negedge clk);
      i2c_transaction <= 1'h0;
      safety_time_write <= 1'h0;
   endtask
endmodule
`default_nettype wire

// ---- verif/css_supervisor_tb_top.sv ----
// Purpose: Self-checking bench for the charge safety supervisor.
// Assumes: Shortened tick, alert, watchdog and duration parameters.
// Notes: Timer figures are checked in windows because the tick phase is free.
`timescale 1ns/1ps
`default_nettype none
module css_supervisor_tb_top;
   import css_pkg::*;
   typedef struct packed {
      logic [3:0] zin;
      logic [1:0] sel;
      logic [2:0] tin;
      logic [2:0] zout;
      int ticks;
   } css_row_type;
   localparam int TK = 4;
   localparam int AL = 10;
   localparam int WD = 5;
   logic clk, srst, input_valid, chip_disable_pin, half_rate_timer_enable, precharge_phase;
   logic other_loop_active, charge_terminated, charge_current_set_pin_gnd, i2c_transaction, charge_enable_n;
   logic [1:0] safety_time_select;
   logic safety_time_write, ts_cold, ts_cool, ts_warm, ts_hot, ts_disabled, die_overtemp;
   logic die_cooled, charge_enable, half_current, vreg_lower, use_default_charge_current_set_pin;
   logic mid_en, sys_en, aux_en, timer_fault, thermal_shutdown, regs_to_default;
   logic alert_o, alert_oe;
   logic [2:0] charge_status;
   int error_cnt = 0;
   int checks = 0;
   int wd_cnt = 0;
   int n;
   // Zones {cool,warm,off,gnd}, select, timer {pre,half,other}, zone outputs, ticks to fault.
   css_row_type rows[6] = '{'{4'h9, 2'h1, 3'h4, 3'h5, 10}, '{4'h4, 2'h1, 3'h7, 3'h2, 20},
      '{4'hF, 2'h1, 3'h6, 3'h1, 10}, '{4'h0, 2'h3, 3'h4, 3'h0, 30},
      '{4'h1, 2'h1, 3'h0, 3'h1, 100}, '{4'h0, 2'h2, 3'h3, 3'h0, 400}};

   css_supervisor #(.TICK_CYCLES(TK), .ALERT_CYCLES(AL), .WDOG_TICKS(WD), .MAX_T1_TICKS(100),
      .MAX_T2_TICKS(200), .MAX_T3_TICKS(300)) u_dut (.clk(clk), .srst(srst),
      .input_valid(input_valid), .chip_disable_pin(chip_disable_pin),
      .charge_enable_n(charge_enable_n), .safety_time_select(safety_time_select),
      .safety_time_write(safety_time_write), .half_rate_timer_enable(half_rate_timer_enable),
      .precharge_phase(precharge_phase), .other_loop_active(other_loop_active),
      .charge_terminated(charge_terminated), .charge_current_set_pin_grounded(charge_current_set_pin_gnd),
      .i2c_transaction(i2c_transaction), .ts_cold(ts_cold), .ts_cool(ts_cool),
      .ts_warm(ts_warm), .ts_hot(ts_hot), .ts_disabled(ts_disabled),
      .die_overtemp(die_overtemp), .die_cooled(die_cooled), .charge_enable(charge_enable),
      .half_current(half_current), .vreg_lower(vreg_lower), .use_default_charge_current_set_pin(use_default_charge_current_set_pin),
      .mid_supply_enable(mid_en), .system_output_enable(sys_en), .aux_output_enable(aux_en),
      .charge_status(charge_status), .timer_fault(timer_fault),
      .thermal_shutdown(thermal_shutdown), .regs_to_default(regs_to_default),
      .host_alert_o(alert_o), .host_alert_oe(alert_oe));
   css_host_model u_host (.clk(clk), .i2c_transaction(i2c_transaction),
      .charge_enable_n(charge_enable_n), .safety_time_select(safety_time_select),
      .safety_time_write(safety_time_write));

   // Free-running clock and quiet inputs at time zero.
   initial begin
      {srst, input_valid, chip_disable_pin, half_rate_timer_enable, precharge_phase} = 5'h18;
      {other_loop_active, charge_terminated, charge_current_set_pin_gnd, ts_cold, ts_cool} = 5'h0;
      {ts_warm, ts_hot, ts_disabled, die_overtemp, die_cooled, clk} = 6'h0;
      forever #2 clk = ~clk;
   end
   // A one-cycle expiry pulse is seen at exactly one falling edge.
   always @(negedge clk) if (regs_to_default === 1'h1) wd_cnt++;

   task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic chk_in(input string what, input int lo, input int hi, input int got);
      checks++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // A negative wd0 waits for the fault flag, otherwise for the expiry count to move.
   // Fault waits must ignore the watchdog, which every bus write rearms.
   task automatic wait_ev(input int wd0, output int k);
      k = 0;
      while (wd0 < 0 ? timer_fault !== 1'h1 : wd_cnt == wd0) begin
         cyc(1);
         k++;
         if (k > 2000) begin
            chk_in("wait bound", 0, 2000, k);
            stop_test();
         end
      end
   endtask
   // Clearing through the disable pin also starts a fresh cycle with a new duration.
   task automatic new_cycle(input logic [1:0] sel);
      chip_disable_pin = 1'h1;
      cyc(2);
      chip_disable_pin = 1'h0;
      u_host.bus_write(1'h0, sel, 1'h1);
   endtask

   // Main sequence.
   initial begin
      cyc(12);
      srst = 1'h0;
      cyc(1);
      chk("reset state", 3'h0, charge_status);
      chk("reset outs", 3'h7, {mid_en, sys_en, aux_en});
      chk("reset drive", 3'h0, {charge_enable, alert_oe, timer_fault});
      cyc(40);
      chk("idle watchdog", 3'h0, wd_cnt[2:0]);
      u_host.bus_write(1'h1, 2'h0, 1'h0);
      wait_ev(0, n);
      chk_in("watchdog time", TK * WD - TK - 1, TK * WD + TK, n);
      cyc(60);
      chk("no rearm", 3'h1, wd_cnt[2:0]);
      repeat (6) begin
         u_host.bus_write(1'h1, 2'h0, 1'h0);
         cyc(10);
      end
      chk("fed watchdog", 3'h1, wd_cnt[2:0]);
      $display("test watchdog done");
      foreach (rows[i]) begin
         {ts_cool, ts_warm, ts_disabled, charge_current_set_pin_gnd} = rows[i].zin;
         {precharge_phase, half_rate_timer_enable, other_loop_active} = rows[i].tin;
         new_cycle(rows[i].sel);
         chk("zones", rows[i].zout, {half_current, vreg_lower, use_default_charge_current_set_pin});
         chk("started", 3'h1, charge_status);
         wait_ev(-1, n);
         chk_in("fault time", (rows[i].ticks - 3) * TK, (rows[i].ticks + 2) * TK, n);
         chk("fault state", 3'h4, charge_status);
         chk("alert level", 3'h0, {charge_enable, alert_o});
         n = 0;
         while (alert_oe === 1'h1 && n < 50) begin
            n++;
            cyc(1);
         end
         chk_in("alert length", AL, AL, n);
      end
      {ts_cool, ts_warm, ts_disabled, precharge_phase, half_rate_timer_enable} = 5'h0;
      $display("test table done");
      u_host.bus_write(1'h1, 2'h1, 1'h1);
      u_host.bus_write(1'h0, 2'h1, 1'h1);
      cyc(3);
      chk("fault latched", 3'h4, charge_status);
      new_cycle(2'h1);
      chip_disable_pin = 1'h1;
      cyc(3);
      chk("pin off", 3'h0, {charge_status[2:1], charge_enable});
      chip_disable_pin = 1'h0;
      cyc(3);
      chk("pin on", 3'h1, charge_status);
      input_valid = 1'h0;
      cyc(3);
      chk("no input", 3'h0, {charge_status[2:1], charge_enable});
      input_valid = 1'h1;
      cyc(3);
      chk("input back", 3'h1, charge_status);
      for (int i = 0; i < 2; i++) begin
         {ts_hot, ts_cold} = (i == 0) ? 2'h2 : 2'h1;
         cyc(3);
         chk("suspend", 3'h2, {charge_status[2:1], charge_enable});
         {ts_hot, ts_cold} = 2'h0;
         cyc(3);
         chk("resume", 3'h1, charge_status);
      end
      charge_terminated = 1'h1;
      cyc(3);
      chk("done", 3'h6, {charge_status[1:0], charge_enable});
      charge_terminated = 1'h0;
      $display("test control done");
      precharge_phase = 1'h1;
      new_cycle(2'h1);
      cyc(20);
      ts_hot = 1'h1;
      cyc(60);
      chk("held", 3'h0, {2'h0, timer_fault});
      ts_hot = 1'h0;
      wait_ev(-1, n);
      chk_in("held remainder", 4, 28, n);
      new_cycle(2'h1);
      cyc(24);
      u_host.bus_write(1'h0, 2'h1, 1'h1);
      wait_ev(-1, n);
      chk_in("restart", 7 * TK, 12 * TK, n);
      new_cycle(2'h1);
      cyc(20);
      die_overtemp = 1'h1;
      cyc(3);
      chk("shutdown", 3'h5, charge_status);
      chk("outputs off", 3'h0, {mid_en, sys_en, aux_en | charge_enable});
      die_overtemp = 1'h0;
      cyc(3);
      chk("hysteresis", 3'h5, {thermal_shutdown, charge_status[1:0]});
      die_cooled = 1'h1;
      cyc(3);
      chk("cooled", 3'h1, charge_status);
      die_cooled = 1'h0;
      wait_ev(-1, n);
      chk_in("timer cleared", 7 * TK, 12 * TK, n);
      $display("test timer hold done");
      stop_test();
   end
endmodule
`default_nettype wire
